// ---- cpu_bsd_cfg.svh ----
`ifndef CPU_BSD_CFG_SVH
`define CPU_BSD_CFG_SVH
// instruction word layout: [15:12] group, [11:8] rn, [7:4] sub, [3:0] low field
`define GRP_MISC 4'h0
`define GRP_COND 4'h1
`define GRP_BRA 4'h2
`define GRP_CALL 4'h3
`define GRP_REG 4'h4
// conditional group: bit 9 selects true/false, bit 8 selects delayed form
`define COND_SEL_BIT 9
`define COND_DLY_BIT 8
// register group sub codes
`define SUB_BRANCH_FAR_REGOFFSET 4'h0
`define SUB_CALLF 4'h1
`define SUB_JMP 4'h2
`define SUB_CALLA 4'h3
`define SUB_RTS 4'h4
`define SUB_LDC_R 4'h5
`define SUB_LDC_M 4'h6
`define SUB_STC_R 4'h7
`define SUB_STC_M 4'h8
`define SUB_LDS_R 4'h9
`define SUB_LDS_M 4'hA
`define SUB_STS_R 4'hB
`define SUB_STS_M 4'hC
`define SUB_CACHE_PREFETCH_OP 4'hD
// misc group codes in the low field
`define MISC_NOP 4'h0
`define MISC_SLEEP 4'h1
`define MISC_RTE 4'h2
`define MISC_CONDITION_FLAG_CLEAR 4'h3
`define MISC_CONDITION_FLAG_SET 4'h4
// control and system register indices
`define CR_SR 3'h0
`define CR_GBR 3'h1
`define CR_VBR 3'h2
`define CR_SSR 3'h3
`define CR_SPC 3'h4
`define SYS_PR 2'h2
`define SR_T_BIT 0
`define SR_RESET 32'h000000F0
// access size codes: log2 of bytes
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2
`define PC_AHEAD 32'h00000004
`define STATES_INIT 8'h01
`endif

// ---- cpu_bsd_pkg.sv ----
package cpu_bsd_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_MEM = 2'h1,
		ST_SLEEP = 2'h2
	} state_e_t;
	typedef enum logic [2:0] {
		MK_LDC = 3'h0,
		MK_LDS = 3'h1,
		MK_STC = 3'h2,
		MK_STS = 3'h3,
		MK_CACHE_PREFETCH_OP = 3'h4
	} mem_kind_t;
	typedef struct packed {
		logic valid;
		logic [15:0] word;
		logic [31:0] pc;
		logic [31:0] rn_val;
	} instr_t;
	typedef struct packed {
		logic valid;
		logic [3:0] idx;
	} load_pend_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic prefetch;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mem_req_t;
	typedef struct packed {
		logic valid;
		logic delayed;
		logic [31:0] target;
	} redirect_t;
	typedef struct packed {
		logic en;
		logic [3:0] idx;
		logic [31:0] data;
	} gpr_wr_t;
endpackage

// ---- cpu_branch_sysctl_decode.sv ----
`include "cpu_bsd_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module cpu_branch_sysctl_decode #(
	parameter int CTRL_REGS = 8,
	parameter int SYS_REGS = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire cpu_bsd_pkg::instr_t instr,
	output logic instr_ready,
	input wire cpu_bsd_pkg::load_pend_t load_pend,
	input wire logic fetch_busy,
	output cpu_bsd_pkg::mem_req_t mem_req,
	input wire logic mem_ready,
	input wire logic [31:0] mem_rdata,
	input wire logic wake,
	output cpu_bsd_pkg::redirect_t redirect,
	output cpu_bsd_pkg::gpr_wr_t gpr_wr,
	output logic cond_flag,
	output logic sleeping,
	output logic retire,
	output logic [7:0] exec_states,
	output logic interlock,
	output logic contention
);
	import cpu_bsd_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		state_e_t st;
		logic ready;
		logic [CTRL_REGS-1:0][31:0] ctrl;
		logic [SYS_REGS-1:0][31:0] sys;
		mem_kind_t p_kind;
		logic [2:0] p_idx;
		logic [3:0] p_rn;
		logic [31:0] p_rn_new;
		logic p_rn_upd;
		mem_req_t mem_req;
		redirect_t redirect;
		gpr_wr_t gpr_wr;
		logic sleeping;
		logic retire;
		logic [7:0] cnt;
		logic [7:0] states;
		logic interlock;
		logic contention;
	} state_t;

	state_t q;
	state_t d;

	// displacement scaled by access size
	function automatic logic [31:0] scale_disp(input logic [31:0] disp, input logic [1:0] size);
		scale_disp = disp << size;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	logic [3:0] grp;
	logic [3:0] rn;
	logic [3:0] sub;
	logic [3:0] lo;
	logic [31:0] pc4;
	logic [31:0] disp8;
	logic [31:0] disp12;
	logic hazard;
	logic take;

	assign grp = instr.word[15:12];
	assign rn = instr.word[11:8];
	assign sub = instr.word[7:4];
	assign lo = instr.word[3:0];
	assign pc4 = instr.pc + `PC_AHEAD;
	assign disp8 = {{24{instr.word[7]}}, instr.word[7:0]};
	assign disp12 = {{20{instr.word[11]}}, instr.word[11:0]};
	// only the register group reads rn; index compared as a plain binary number
	assign hazard = load_pend.valid && (load_pend.idx == rn) && (grp == `GRP_REG);
	assign take = instr.valid && q.ready && !hazard;

	always_comb begin
		d = q;
		d.redirect.valid = 1'b0;
		d.redirect.delayed = 1'b0;
		d.gpr_wr.en = 1'b0;
		d.retire = 1'b0;
		d.interlock = 1'b0;
		d.contention = 1'b0;
		case (q.st)
		ST_IDLE: begin
			if (instr.valid && q.ready && hazard) begin
				d.interlock = 1'b1;
				d.cnt = q.cnt + 8'h01;
			end else if (take) begin
				d.retire = 1'b1;
				d.states = q.cnt;
				d.cnt = `STATES_INIT;
				case (grp)
				`GRP_COND: begin
					// true form follows the flag, false form its inverse
					if (instr.word[`COND_SEL_BIT] == q.ctrl[`CR_SR][`SR_T_BIT]) begin
						d.redirect.valid = 1'b1;
						d.redirect.delayed = instr.word[`COND_DLY_BIT];
						d.redirect.target = pc4 + scale_disp(disp8, `SZ_WORD);
					end
				end
				`GRP_BRA, `GRP_CALL: begin
					d.redirect.valid = 1'b1;
					d.redirect.delayed = 1'b1;
					d.redirect.target = pc4 + scale_disp(disp12, `SZ_WORD);
					if (grp == `GRP_CALL) begin
						d.sys[`SYS_PR] = pc4;
					end
				end
				`GRP_REG: begin
					d.p_rn = rn;
					d.p_rn_upd = 1'b0;
					d.mem_req.size = `SZ_LONG;
					d.mem_req.write = 1'b0;
					d.mem_req.prefetch = 1'b0;
					case (sub)
					`SUB_BRANCH_FAR_REGOFFSET, `SUB_CALLF, `SUB_JMP, `SUB_CALLA, `SUB_RTS: begin
						d.redirect.valid = 1'b1;
						d.redirect.delayed = 1'b1;
						d.redirect.target = (sub == `SUB_RTS) ? q.sys[`SYS_PR] :
							(sub == `SUB_BRANCH_FAR_REGOFFSET || sub == `SUB_CALLF) ? pc4 + instr.rn_val : instr.rn_val;
						if (sub == `SUB_CALLF || sub == `SUB_CALLA) begin
							d.sys[`SYS_PR] = pc4;
						end
					end
					`SUB_LDC_R: begin
						d.ctrl[lo[2:0]] = instr.rn_val;
					end
					`SUB_LDS_R: begin
						d.sys[lo[1:0]] = instr.rn_val;
					end
					`SUB_STC_R, `SUB_STS_R: begin
						d.gpr_wr.en = 1'b1;
						d.gpr_wr.idx = rn;
						d.gpr_wr.data = (sub == `SUB_STC_R) ? q.ctrl[lo[2:0]] : q.sys[lo[1:0]];
					end
					`SUB_LDC_M, `SUB_LDS_M, `SUB_STC_M, `SUB_STS_M, `SUB_CACHE_PREFETCH_OP: begin
						// memory forms: post-increment load, pre-decrement store, prefetch by displacement
						d.retire = 1'b0;
						d.states = q.states;
						d.cnt = q.cnt + 8'h01;
						d.st = ST_MEM;
						d.ready = 1'b0;
						d.p_idx = lo[2:0];
						d.p_rn_upd = (sub != `SUB_CACHE_PREFETCH_OP);
						d.mem_req.addr = instr.rn_val;
						d.p_rn_new = instr.rn_val + scale_disp(32'h00000001, `SZ_LONG);
						d.p_kind = (sub == `SUB_LDC_M) ? MK_LDC : (sub == `SUB_LDS_M) ? MK_LDS : MK_CACHE_PREFETCH_OP;
						if (sub == `SUB_STC_M || sub == `SUB_STS_M) begin
							d.p_kind = (sub == `SUB_STC_M) ? MK_STC : MK_STS;
							d.mem_req.write = 1'b1;
							d.mem_req.addr = instr.rn_val - scale_disp(32'h00000001, `SZ_LONG);
							d.p_rn_new = d.mem_req.addr;
							d.mem_req.wdata = (sub == `SUB_STC_M) ? q.ctrl[lo[2:0]] : q.sys[lo[1:0]];
						end
						if (sub == `SUB_CACHE_PREFETCH_OP) begin
							d.mem_req.prefetch = 1'b1;
							d.mem_req.addr = instr.rn_val + scale_disp({28'h0000000, lo}, `SZ_LONG);
						end
						// the fetch owns the bus this cycle, so the data access waits
						d.mem_req.valid = !fetch_busy;
						d.contention = fetch_busy;
					end
					default: begin
					end
					endcase
				end
				`GRP_MISC: begin
					case (lo)
					`MISC_SLEEP: begin
						// retirement is deferred to the wake-up
						d.retire = 1'b0;
						d.states = q.states;
						d.st = ST_SLEEP;
						d.ready = 1'b0;
						d.sleeping = 1'b1;
					end
					`MISC_RTE: begin
						d.redirect.valid = 1'b1;
						d.redirect.delayed = 1'b1;
						d.redirect.target = q.ctrl[`CR_SPC];
						d.ctrl[`CR_SR] = q.ctrl[`CR_SSR];
					end
					`MISC_CONDITION_FLAG_CLEAR: begin
						d.ctrl[`CR_SR][`SR_T_BIT] = 1'b0;
					end
					`MISC_CONDITION_FLAG_SET: begin
						d.ctrl[`CR_SR][`SR_T_BIT] = 1'b1;
					end
					default: begin
					end
					endcase
				end
				default: begin
				end
				endcase
			end
		end
		ST_MEM: begin
			if (q.mem_req.valid && mem_ready) begin
				d.mem_req.valid = 1'b0;
				d.st = ST_IDLE;
				d.ready = 1'b1;
				d.retire = 1'b1;
				d.states = q.cnt;
				d.cnt = `STATES_INIT;
				if (q.p_kind == MK_LDC) begin
					d.ctrl[q.p_idx] = mem_rdata;
				end
				if (q.p_kind == MK_LDS) begin
					d.sys[q.p_idx[1:0]] = mem_rdata;
				end
				d.gpr_wr.en = q.p_rn_upd;
				d.gpr_wr.idx = q.p_rn;
				d.gpr_wr.data = q.p_rn_new;
			end else begin
				// each wait state or lost arbitration adds a state
				d.cnt = q.cnt + 8'h01;
				if (!q.mem_req.valid) begin
					d.mem_req.valid = !fetch_busy;
					d.contention = fetch_busy;
				end
			end
		end
		ST_SLEEP: begin
			if (wake) begin
				d.st = ST_IDLE;
				d.ready = 1'b1;
				d.sleeping = 1'b0;
				d.retire = 1'b1;
				d.states = q.cnt;
				d.cnt = `STATES_INIT;
			end
		end
		default: begin
			d.st = ST_IDLE;
			d.ready = 1'b1;
		end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '0;
			q.st <= ST_IDLE;
			q.ready <= 1'b1;
			q.ctrl[`CR_SR] <= `SR_RESET;
			q.cnt <= `STATES_INIT;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign instr_ready = q.ready;
	assign mem_req = q.mem_req;
	assign redirect = q.redirect;
	assign gpr_wr = q.gpr_wr;
	assign cond_flag = q.ctrl[`CR_SR][`SR_T_BIT];
	assign sleeping = q.sleeping;
	assign retire = q.retire;
	assign exec_states = q.states;
	assign interlock = q.interlock;
	assign contention = q.contention;
endmodule // cpu_branch_sysctl_decode
`default_nettype wire

// ---- cbd_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module cbd_mem_model (
	input wire logic clk,
	input wire cpu_bsd_pkg::mem_req_t req,
	input wire logic [1:0] waits,
	output logic ready,
	output logic [31:0] rdata
);
	logic [1:0] cnt_q;
	// read data keeps moving through wait states so a stale word never passes
	assign ready = req.valid && cnt_q == waits;
	assign rdata = ready ? ~req.addr : {30'h16969696, cnt_q};
	always_ff @(posedge clk) begin
		cnt_q <= (req.valid && !ready) ? cnt_q + 2'h1 : 2'h0;
	end
endmodule // cbd_mem_model
`default_nettype wire

// ---- cbd_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module cbd_assertions (
	input wire logic clk,
	input wire logic srst,
	input wire cpu_bsd_pkg::instr_t instr,
	input wire logic instr_ready,
	input wire cpu_bsd_pkg::load_pend_t load_pend,
	input wire logic fetch_busy,
	input wire cpu_bsd_pkg::mem_req_t mem_req,
	input wire logic mem_ready,
	input wire cpu_bsd_pkg::redirect_t redirect,
	input wire cpu_bsd_pkg::gpr_wr_t gpr_wr,
	input wire logic cond_flag,
	input wire logic sleeping,
	input wire logic retire,
	input wire logic interlock,
	input wire logic contention
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic tk, hz;
	assign tk = instr.valid && instr_ready;
	assign hz = load_pend.valid && load_pend.idx == instr.word[11:8] && instr.word[15:12] == 4'h4;
	bf_redirect_a: assert property (tk && instr.word[15:12] == 4'h1 && !instr.word[9]
		|=> redirect.valid == !$past(cond_flag)) else $error("false branch wrong");
	bt_redirect_a: assert property (tk && instr.word[15:12] == 4'h1 && instr.word[9]
		|=> redirect.valid == $past(cond_flag)) else $error("true branch wrong");
	sleep_enter_a: assert property (tk && instr.word == 16'h0001
		|=> sleeping && !instr_ready) else $error("no power-down");
	cache_prefetch_op_nowrite_a: assert property (mem_req.valid && mem_req.prefetch && mem_ready
		|=> retire && !gpr_wr.en) else $error("prefetch wrote register");
	mem_hold_a: assert property (mem_req.valid && !mem_ready
		|=> mem_req.valid && $stable(mem_req) && !retire) else $error("wait state lost");
	fetch_clash_a: assert property (tk && !hz && instr.word[15:12] == 4'h4
		&& instr.word[7:4] inside {4'h6, 4'h8, 4'hA, 4'hC, 4'hD}
		&& fetch_busy |=> contention && !mem_req.valid) else $error("no contention stall");
	rte_resume_a: assert property (tk && instr.word == 16'h0002
		|=> redirect.valid && redirect.delayed) else $error("no exception return");
	load_hold_a: assert property (tk && hz |=> interlock && !retire) else $error("no interlock");
	reg_field_a: assert property (tk && !hz && instr.word[15:8] == 8'h4F && instr.word[7:4] == 4'h7
		|=> gpr_wr.en && gpr_wr.idx == 4'hF) else $error("wrong register");
endmodule // cbd_assertions
bind cpu_branch_sysctl_decode cbd_assertions chk_i (.clk, .srst, .instr, .instr_ready, .load_pend, .fetch_busy,
	.mem_req, .mem_ready, .redirect, .gpr_wr, .cond_flag, .sleeping, .retire, .interlock, .contention);
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import cpu_bsd_pkg::*;
	logic clk, srst, instr_ready, fetch_busy, mem_ready, wake, cond_flag, sleeping, retire, interlock, contention;
	logic [31:0] mem_rdata, a, d;
	logic [7:0] exec_states;
	logic [1:0] mem_waits;
	instr_t instr;
	load_pend_t load_pend;
	mem_req_t mem_req;
	redirect_t redirect;
	gpr_wr_t gpr_wr;
	int err_count, compares;
	cpu_branch_sysctl_decode dut (.clk, .srst, .instr, .instr_ready, .load_pend, .fetch_busy, .mem_req,
		.mem_ready, .mem_rdata, .wake, .redirect, .gpr_wr, .cond_flag, .sleeping, .retire, .exec_states,
		.interlock, .contention);
	cbd_mem_model mem_i (.clk, .req(mem_req), .waits(mem_waits), .ready(mem_ready), .rdata(mem_rdata));
	////////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [63:0] e, logic [63:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// offer at a falling edge, drop valid one falling edge after the taking edge
	task automatic issue(logic [15:0] w, logic [31:0] rn);
		int n;
		n = 0;
		// one idle edge first, so valid never falls and rises in the same step
		@(negedge clk);
		instr = '{1'b1, w, 32'h100, rn};
		while (!instr_ready && n < 50) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		instr.valid = 1'b0;
	endtask
	task automatic wait_ret;
		for (int n = 0; n < 20 && !retire; n++) begin
			if (mem_req.valid) begin
				a = mem_req.addr;
				d = mem_req.wdata;
			end
			@(negedge clk);
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_cond;
		for (int k = 0; k < 8; k++) begin
			issue({12'h000, k[2] ? 4'h4 : 4'h3}, 0);
			issue({6'h04, k[1:0], 8'h03}, 0);
			chk("taken", k[1] == k[2], redirect.valid);
			if (k[1] == k[2]) chk("target", 32'h10A, redirect.target);
			if (k[1] == k[2]) chk("delayed", k[0], redirect.delayed);
			chk("states", 1, exec_states);
		end
		$display("cond done");
	endtask
	task automatic t_ctrl;
		issue(16'h4053, 32'h1);
		issue(16'h4054, 32'h200);
		issue(16'h4F74, 0);
		chk("gpr", {1'b1, 4'hF, 32'h200}, gpr_wr);
		issue(16'h0003, 0);
		issue(16'h0002, 0);
		chk("rte", {1'b1, 32'h200}, {redirect.valid, redirect.target});
		chk("sr", 1, cond_flag);
		$display("ctrl done");
	endtask
	task automatic t_mem;
		issue(16'h3000, 0);
		mem_waits = 2'h1;
		fetch_busy = 1'b1;
		issue(16'h42C2, 32'h1000);
		chk("clash", 1, contention);
		fetch_busy = 1'b0;
		wait_ret;
		chk("write", 1, mem_req.write);
		chk("addr", 32'hFFC, a);
		chk("wdata", 32'h104, d);
		chk("states", 4, exec_states);
		chk("gpr", {1'b1, 4'h2, 32'hFFC}, gpr_wr);
		mem_waits = 2'h0;
		$display("mem done");
	endtask
	task automatic t_cache_prefetch_op;
		issue(16'h43D5, 32'h2000);
		wait_ret;
		chk("addr", 32'h2014, a);
		chk("wr", 0, gpr_wr.en);
		chk("pf", {1'b1, 2'h2}, {mem_req.prefetch, mem_req.size});
		issue(16'h4163, 32'h300);
		wait_ret;
		chk("inc", 32'h304, gpr_wr.data);
		issue(16'h4073, 0);
		chk("ssr", 32'hFFFFFCFF, gpr_wr.data);
		$display("cache_prefetch_op done");
	endtask
	task automatic t_hazard;
		@(negedge clk);
		load_pend = '{1'b1, 4'h5};
		instr = '{1'b1, 16'h4574, 32'h100, 32'h0};
		repeat (2) @(negedge clk);
		chk("ilk", 1, interlock);
		chk("ret", 0, retire);
		load_pend.valid = 1'b0;
		@(negedge clk);
		instr.valid = 1'b0;
		chk("gpr", {1'b1, 4'h5, 32'h200}, gpr_wr);
		chk("states", 3, exec_states);
		$display("hazard done");
	endtask
	task automatic t_sleep;
		issue(16'h0001, 0);
		repeat (3) @(negedge clk);
		chk("sleep", 1, sleeping);
		chk("rdy", 0, instr_ready);
		wake = 1'b1;
		wait_ret;
		wake = 1'b0;
		chk("awake", 0, sleeping);
		chk("states", 1, exec_states);
		$display("sleep done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		complete_run;
	end
	initial begin
		srst = 1'b1;
		instr = '0;
		load_pend = '0;
		fetch_busy = 1'b0;
		wake = 1'b0;
		mem_waits = 2'h0;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		chk("reset", 1, instr_ready);
		t_cond;
		t_ctrl;
		t_mem;
		t_cache_prefetch_op;
		t_hazard;
		t_sleep;
		complete_run;
	end
endmodule // testbench
`default_nettype wire
